// [hdl/wd_pkg.sv]
// Constants shared by the dual watchdog design
package wd_pkg;
   localparam int CLK_HZ   = 100_000_000;
   localparam int TICK_HZ  = 32_768;
   // Nearest whole divide; the tick runs 0.008 % slow
   localparam int TICK_DIV = (CLK_HZ + TICK_HZ / 2) / TICK_HZ;
   localparam int TICK_W   = 12;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

   localparam int ADDR_W = 16;
   localparam int CNT_W  = 24;
   localparam int NCH    = 2;
   localparam int CH_LEG = 0;
   localparam int CH_DIR = 1;

   localparam logic [ADDR_W-1:0] PORT_INDEX   = 16'h0022;
   localparam logic [ADDR_W-1:0] PORT_DATA    = 16'h0023;
   localparam logic [ADDR_W-1:0] PORT_RELOAD  = 16'h0067;
   localparam logic [ADDR_W-1:0] PORT_CTRL    = 16'h0068;
   localparam logic [ADDR_W-1:0] PORT_ACT     = 16'h0069;
   localparam logic [ADDR_W-1:0] PORT_LIM_LO  = 16'h006a;
   localparam logic [ADDR_W-1:0] PORT_LIM_MID = 16'h006b;
   localparam logic [ADDR_W-1:0] PORT_LIM_HI  = 16'h006c;
   localparam logic [ADDR_W-1:0] PORT_STATUS  = 16'h006d;

   localparam logic [7:0] IDX_ENABLE  = 8'h37;
   localparam logic [7:0] IDX_ACT     = 8'h38;
   localparam logic [7:0] IDX_LIM_LO  = 8'h39;
   localparam logic [7:0] IDX_LIM_MID = 8'h3a;
   localparam logic [7:0] IDX_LIM_HI  = 8'h3b;
   localparam logic [7:0] IDX_STATUS  = 8'h3c;

   localparam int EN_BIT   = 6;
   localparam int SVC_BIT  = 6;
   localparam int FLAG_BIT = 7;
   localparam int ACT_LSB  = 4;

   localparam logic       LEG_EN_RST  = 1'b1;
   localparam logic       DIR_EN_RST  = 1'b0;
   localparam logic [7:0] BYTE_RST    = 8'h00;
   localparam logic [3:0] ACT_RST     = 4'h0;
   localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
   localparam logic [15:0] IRQ_NONE   = 16'h0000;

   typedef enum logic [3:0] {
      ACT_IRQ3  = 4'b0001,
      ACT_IRQ4  = 4'b0010,
      ACT_IRQ5  = 4'b0011,
      ACT_IRQ6  = 4'b0100,
      ACT_IRQ7  = 4'b0101,
      ACT_IRQ9  = 4'b0110,
      ACT_IRQ10 = 4'b0111,
      ACT_IRQ12 = 4'b1001,
      ACT_IRQ14 = 4'b1010,
      ACT_IRQ15 = 4'b1011,
      ACT_NMI   = 4'b1100,
      ACT_RESET = 4'b1101
   } act_type;
endpackage

// [hdl/wd_core.sv]
// One 24-bit up-counting watchdog channel
`timescale 1ns/10ps
module wd_core
   import wd_pkg::*;
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_tick,
   input  wire logic             i_enable,
   input  wire logic             i_restart,
   input  wire logic [CNT_W-1:0] i_limit,
   output logic                  o_timeout,
   output logic      [CNT_W-1:0] o_count
);
   logic [CNT_W-1:0] cnt_ff;
   logic             tmo_ff;
   logic [CNT_W-1:0] cnt_inc;
   logic             step;
   logic [CNT_W-1:0] nxt_cnt;
   logic             nxt_tmo;

   // Counter parks at the limit so one expiry gives one event
   assign cnt_inc = cnt_ff + 24'h00_0001;
   assign step    = i_enable && !i_restart && i_tick && (cnt_ff != i_limit);
   assign nxt_cnt = (!i_enable || i_restart) ? CNT_RST : (step ? cnt_inc : cnt_ff);
   assign nxt_tmo = step && (cnt_inc == i_limit);

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_ff <= CNT_RST;
         tmo_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         tmo_ff <= nxt_tmo;
      end
   end

   assign o_timeout = tmo_ff;
   assign o_count   = cnt_ff;

   property p_disable_clears;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      !i_enable |=> (cnt_ff == CNT_RST);
   endproperty
   a_disable_clears: assert property (p_disable_clears) else $error("count not cleared on disable");

   property p_count_step;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_enable && !i_restart && i_tick && cnt_ff != i_limit) |=> (cnt_ff == $past(cnt_ff) + 24'h00_0001);
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step on tick");

   property p_timeout_at_limit;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      tmo_ff |-> (cnt_ff == $past(i_limit)) && ($past(cnt_ff) != cnt_ff);
   endproperty
   a_timeout_at_limit: assert property (p_timeout_at_limit) else $error("timeout away from limit");
endmodule

// [hdl/dual_watchdog_timers.sv]
// Legacy and direct watchdog timers with their I/O port register file
`timescale 1ns/10ps
module dual_watchdog_timers
   import wd_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   input  wire logic [ADDR_W-1:0] i_io_addr,
   input  wire logic [7:0]        i_io_wdata,
   input  wire logic              i_io_wr,
   input  wire logic              i_io_rd,
   output logic      [7:0]        o_io_rdata,
   output logic      [15:0]       o_irq,
   output logic                   o_nmi,
   output logic                   o_sys_rst_req
);
   import wd_pkg::*;

   // Register file
   logic [7:0]       idx_ff;
   logic             leg_en_ff;
   logic [3:0]       leg_act_ff;
   logic [CNT_W-1:0] leg_lim_ff;
   logic             leg_flag_ff;
   logic             dir_en_ff;
   logic [3:0]       dir_act_ff;
   logic [CNT_W-1:0] dir_lim_ff;
   logic             dir_flag_ff;
   logic [7:0]       rdata_ff;
   logic [15:0]      irq_ff;
   logic             nmi_ff;
   logic             rst_req_ff;
   logic [TICK_W-1:0] tick_cnt_ff;
   logic             tick_ff;

   // Port decode
   logic wr_index;
   logic wr_data;
   logic wr_leg_en;
   logic wr_leg_act;
   logic wr_leg_lo;
   logic wr_leg_mid;
   logic wr_leg_hi;
   logic wr_leg_svc;
   logic wr_reload;
   logic wr_ctrl;
   logic wr_dir_act;
   logic wr_dir_lo;
   logic wr_dir_mid;
   logic wr_dir_hi;
   logic wr_status;

   assign wr_index   = i_io_wr && (i_io_addr == PORT_INDEX);
   assign wr_data    = i_io_wr && (i_io_addr == PORT_DATA);
   assign wr_leg_en  = wr_data && (idx_ff == IDX_ENABLE);
   assign wr_leg_act = wr_data && (idx_ff == IDX_ACT);
   assign wr_leg_lo  = wr_data && (idx_ff == IDX_LIM_LO);
   assign wr_leg_mid = wr_data && (idx_ff == IDX_LIM_MID);
   assign wr_leg_hi  = wr_data && (idx_ff == IDX_LIM_HI);
   assign wr_leg_svc = wr_data && (idx_ff == IDX_STATUS) && i_io_wdata[SVC_BIT];
   assign wr_reload  = i_io_wr && (i_io_addr == PORT_RELOAD);
   assign wr_ctrl    = i_io_wr && (i_io_addr == PORT_CTRL);
   assign wr_dir_act = i_io_wr && (i_io_addr == PORT_ACT);
   assign wr_dir_lo  = i_io_wr && (i_io_addr == PORT_LIM_LO);
   assign wr_dir_mid = i_io_wr && (i_io_addr == PORT_LIM_MID);
   assign wr_dir_hi  = i_io_wr && (i_io_addr == PORT_LIM_HI);
   assign wr_status  = i_io_wr && (i_io_addr == PORT_STATUS);

   // Tick generator shared by both channels
   logic              tick_wrap;
   logic [TICK_W-1:0] nxt_tick_cnt;

   assign tick_wrap    = (tick_cnt_ff == TICK_LAST);
   assign nxt_tick_cnt = tick_wrap ? '0 : tick_cnt_ff + 12'h001;

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b0;
      end
      else
      begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff     <= tick_wrap;
      end
   end

   // Channel wiring: index 0 legacy, index 1 direct
   logic [NCH-1:0]   ch_en;
   logic [NCH-1:0]   ch_restart;
   logic [NCH-1:0]   ch_timeout;
   logic [NCH-1:0]   ch_flag;
   logic [CNT_W-1:0] ch_limit [NCH];
   logic [CNT_W-1:0] ch_count [NCH];
   logic [3:0]       ch_act   [NCH];
   logic [15:0]      ch_irq   [NCH];
   logic [NCH-1:0]   ch_nmi;
   logic [NCH-1:0]   ch_rst;

   assign ch_en[CH_LEG]      = leg_en_ff;
   assign ch_en[CH_DIR]      = dir_en_ff;
   assign ch_restart[CH_LEG] = wr_leg_svc;
   assign ch_restart[CH_DIR] = wr_reload;
   assign ch_limit[CH_LEG]   = leg_lim_ff;
   assign ch_limit[CH_DIR]   = dir_lim_ff;
   assign ch_act[CH_LEG]     = leg_act_ff;
   assign ch_act[CH_DIR]     = dir_act_ff;
   assign ch_flag[CH_LEG]    = leg_flag_ff;
   assign ch_flag[CH_DIR]    = dir_flag_ff;

   function automatic logic [15:0] irq_mask(input logic [3:0] code);
      logic [15:0] m;
      m = IRQ_NONE;
      case (code)
         ACT_IRQ3:  m[3]  = 1'b1;
         ACT_IRQ4:  m[4]  = 1'b1;
         ACT_IRQ5:  m[5]  = 1'b1;
         ACT_IRQ6:  m[6]  = 1'b1;
         ACT_IRQ7:  m[7]  = 1'b1;
         ACT_IRQ9:  m[9]  = 1'b1;
         ACT_IRQ10: m[10] = 1'b1;
         ACT_IRQ12: m[12] = 1'b1;
         ACT_IRQ14: m[14] = 1'b1;
         ACT_IRQ15: m[15] = 1'b1;
         default:   m = IRQ_NONE;
      endcase
      return m;
   endfunction

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         wd_core u_core (
            .i_sys_clk (i_sys_clk),
            .i_nrst    (i_nrst),
            .i_tick    (tick_ff),
            .i_enable  (ch_en[g]),
            .i_restart (ch_restart[g]),
            .i_limit   (ch_limit[g]),
            .o_timeout (ch_timeout[g]),
            .o_count   (ch_count[g])
         );
         // IRQ and NMI follow the sticky flag; reset fires once on the event
         assign ch_irq[g] = ch_flag[g] ? irq_mask(ch_act[g]) : IRQ_NONE;
         assign ch_nmi[g] = ch_flag[g] && (ch_act[g] == ACT_NMI);
         assign ch_rst[g] = ch_timeout[g] && (ch_act[g] == ACT_RESET);
      end
   endgenerate

   // Status flags: a timeout in the clearing cycle wins
   logic nxt_leg_flag;
   logic nxt_dir_flag;

   assign nxt_leg_flag = ch_timeout[CH_LEG] || (leg_flag_ff && !wr_leg_svc);
   assign nxt_dir_flag = ch_timeout[CH_DIR] || (dir_flag_ff && !(wr_status && i_io_wdata[FLAG_BIT]));

   // Read mux; reserved bits, unknown indices and direct_wd_reload read zero
   logic [7:0] leg_rd;
   logic [7:0] dir_rd;
   logic [7:0] nxt_rdata;

   assign leg_rd = (idx_ff == IDX_ENABLE)  ? {1'b0, leg_en_ff, 6'h00} :
                   (idx_ff == IDX_ACT)     ? {leg_act_ff, 4'h0} :
                   (idx_ff == IDX_LIM_LO)  ? leg_lim_ff[7:0] :
                   (idx_ff == IDX_LIM_MID) ? leg_lim_ff[15:8] :
                   (idx_ff == IDX_LIM_HI)  ? leg_lim_ff[23:16] :
                   (idx_ff == IDX_STATUS)  ? {leg_flag_ff, 7'h00} : BYTE_RST;
   assign dir_rd = (i_io_addr == PORT_CTRL)    ? {1'b0, dir_en_ff, 6'h00} :
                   (i_io_addr == PORT_ACT)     ? {dir_act_ff, 4'h0} :
                   (i_io_addr == PORT_LIM_LO)  ? dir_lim_ff[7:0] :
                   (i_io_addr == PORT_LIM_MID) ? dir_lim_ff[15:8] :
                   (i_io_addr == PORT_LIM_HI)  ? dir_lim_ff[23:16] :
                   (i_io_addr == PORT_STATUS)  ? {dir_flag_ff, 7'h00} : BYTE_RST;
   assign nxt_rdata = !i_io_rd ? rdata_ff :
                      (i_io_addr == PORT_INDEX) ? idx_ff :
                      (i_io_addr == PORT_DATA)  ? leg_rd : dir_rd;

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         idx_ff     <= BYTE_RST;
         leg_en_ff  <= LEG_EN_RST;
         leg_act_ff <= ACT_RST;
         leg_lim_ff <= CNT_RST;
         dir_en_ff  <= DIR_EN_RST;
         dir_act_ff <= ACT_RST;
         dir_lim_ff <= CNT_RST;
      end
      else
      begin
         if (wr_index)
            idx_ff <= i_io_wdata;
         if (wr_leg_en)
            leg_en_ff <= i_io_wdata[EN_BIT];
         if (wr_leg_act)
            leg_act_ff <= i_io_wdata[7:ACT_LSB];
         if (wr_leg_lo)
            leg_lim_ff[7:0] <= i_io_wdata;
         if (wr_leg_mid)
            leg_lim_ff[15:8] <= i_io_wdata;
         if (wr_leg_hi)
            leg_lim_ff[23:16] <= i_io_wdata;
         if (wr_ctrl)
            dir_en_ff <= i_io_wdata[EN_BIT];
         if (wr_dir_act)
            dir_act_ff <= i_io_wdata[7:ACT_LSB];
         if (wr_dir_lo)
            dir_lim_ff[7:0] <= i_io_wdata;
         if (wr_dir_mid)
            dir_lim_ff[15:8] <= i_io_wdata;
         if (wr_dir_hi)
            dir_lim_ff[23:16] <= i_io_wdata;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         leg_flag_ff <= 1'b0;
         dir_flag_ff <= 1'b0;
         rdata_ff    <= BYTE_RST;
         irq_ff      <= IRQ_NONE;
         nmi_ff      <= 1'b0;
         rst_req_ff  <= 1'b0;
      end
      else
      begin
         leg_flag_ff <= nxt_leg_flag;
         dir_flag_ff <= nxt_dir_flag;
         rdata_ff    <= nxt_rdata;
         irq_ff      <= ch_irq[CH_LEG] | ch_irq[CH_DIR];
         nmi_ff      <= |ch_nmi;
         rst_req_ff  <= |ch_rst;
      end
   end

   assign o_io_rdata    = rdata_ff;
   assign o_irq         = irq_ff;
   assign o_nmi         = nmi_ff;
   assign o_sys_rst_req = rst_req_ff;

   property p_index_latch;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      wr_index |=> (idx_ff == $past(i_io_wdata));
   endproperty
   a_index_latch: assert property (p_index_latch) else $error("index port not latched");

   property p_tick_spacing;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      tick_ff |=> !tick_ff [*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

   property p_leg_flag_set;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      ch_timeout[CH_LEG] |=> leg_flag_ff;
   endproperty
   a_leg_flag_set: assert property (p_leg_flag_set) else $error("legacy flag not set");

   property p_leg_service;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (wr_leg_svc && leg_en_ff) |=> (ch_count[CH_LEG] == CNT_RST);
   endproperty
   a_leg_service: assert property (p_leg_service) else $error("service write did not restart");

   property p_dir_reload;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      wr_reload |=> (ch_count[CH_DIR] == CNT_RST) && !ch_timeout[CH_DIR];
   endproperty
   a_dir_reload: assert property (p_dir_reload) else $error("reload write did not clear count");

   property p_dir_w1c;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (wr_status && i_io_wdata[FLAG_BIT] && !ch_timeout[CH_DIR]) |=> !dir_flag_ff;
   endproperty
   a_dir_w1c: assert property (p_dir_w1c) else $error("direct flag not cleared");

   property p_dir_flag_sticky;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (dir_flag_ff && !(wr_status && i_io_wdata[FLAG_BIT])) |=> dir_flag_ff;
   endproperty
   a_dir_flag_sticky: assert property (p_dir_flag_sticky) else $error("direct flag lost");

   property p_nmi_follows;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (dir_flag_ff && dir_act_ff == ACT_NMI) |=> o_nmi;
   endproperty
   a_nmi_follows: assert property (p_nmi_follows) else $error("nmi not raised");

   property p_rst_pulse;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (ch_timeout[CH_LEG] && leg_act_ff == ACT_RESET) || (ch_timeout[CH_DIR] && dir_act_ff == ACT_RESET)
      |=> o_sys_rst_req ##1 !o_sys_rst_req;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset request not a single pulse");
endmodule

// [verification/host_io_model.sv]
// Host software model that drives the watchdog I/O port bus
`timescale 1ns/10ps
module host_io_model
   import wd_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic [7:0]        i_io_rdata,
   output logic      [ADDR_W-1:0] o_io_addr,
   output logic      [7:0]        o_io_wdata,
   output logic                   o_io_wr,
   output logic                   o_io_rd
);
   initial
   begin
      o_io_addr  = 16'h0000;
      o_io_wdata = 8'h00;
      o_io_wr    = 1'b0;
      o_io_rd    = 1'b0;
   end

   // Data is inverted once the strobe drops so a stale byte never looks valid
   task automatic io_write(input logic [ADDR_W-1:0] addr, input logic [7:0] data);
      @(negedge i_sys_clk);
      o_io_addr  = addr;
      o_io_wdata = data;
      o_io_wr    = 1'b1;
      @(negedge i_sys_clk);
      o_io_wr    = 1'b0;
      o_io_wdata = ~data;
   endtask

   task automatic io_read(input logic [ADDR_W-1:0] addr, output logic [7:0] data);
      @(negedge i_sys_clk);
      o_io_addr = addr;
      o_io_rd   = 1'b1;
      @(negedge i_sys_clk);
      o_io_rd   = 1'b0;
      data      = i_io_rdata;
   endtask

   task automatic leg_write(input logic [7:0] idx, input logic [7:0] data);
      io_write(PORT_INDEX, idx);
      io_write(PORT_DATA, data);
   endtask

   task automatic leg_read(input logic [7:0] idx, output logic [7:0] data);
      io_write(PORT_INDEX, idx);
      io_read(PORT_DATA, data);
   endtask

   // Leaves the legacy watchdog disabled; the caller enables it afterwards
   task automatic leg_set_limit(input logic [CNT_W-1:0] value);
      leg_write(IDX_ENABLE, 8'h00);
      leg_write(IDX_LIM_HI, value[23:16]);
      leg_write(IDX_LIM_MID, value[15:8]);
      leg_write(IDX_LIM_LO, value[7:0]);
   endtask

   task automatic reload(input logic [7:0] data);
      io_write(PORT_RELOAD, data);
   endtask
endmodule

// [verification/dual_watchdog_timers_test.sv]
// Self-checking bench for the dual watchdog timers
`timescale 1ns/10ps
module dual_watchdog_timers_test;
   import wd_pkg::*;
   logic              clk;
   logic              nrst;
   logic [ADDR_W-1:0] io_addr;
   logic [7:0]        io_wdata;
   logic              io_wr;
   logic              io_rd;
   logic [7:0]        io_rdata;
   logic [15:0]       irq;
   logic              nmi;
   logic              rst_req;
   logic [7:0]        rd;
   int                n;
   int                failures  = 0;
   int                tests_run = 0;
   logic [3:0]        code_tab [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc};
   logic [15:0]       irq_tab [11]  = '{16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0200,
                                        16'h0400, 16'h1000, 16'h4000, 16'h8000, 16'h0000};

   dual_watchdog_timers dut (
      .i_sys_clk     (clk),
      .i_nrst        (nrst),
      .i_io_addr     (io_addr),
      .i_io_wdata    (io_wdata),
      .i_io_wr       (io_wr),
      .i_io_rd       (io_rd),
      .o_io_rdata    (io_rdata),
      .o_irq         (irq),
      .o_nmi         (nmi),
      .o_sys_rst_req (rst_req)
   );

   host_io_model host (
      .i_sys_clk  (clk),
      .i_io_rdata (io_rdata),
      .o_io_addr  (io_addr),
      .o_io_wdata (io_wdata),
      .o_io_wr    (io_wr),
      .o_io_rd    (io_rd)
   );

   initial
   begin
      clk  = 1'b0;
      nrst = 1'b0;
   end

   always #5 clk = ~clk;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic end_test(input string name);
      $display("test %s finished", name);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Bounded wait for any timeout output; one tick is 3052 cycles
   task automatic wait_evt(input int lim);
      n = 0;
      while (irq === 16'h0000 && nmi !== 1'b1 && rst_req !== 1'b1 && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      chk("event within bound", 16'h0001, 16'(n < lim));
   endtask

   initial
   begin
      // Worst case of all bounded waits is about 75000 cycles; stop at 95000, about 20000 above it
      #950_000;
      failures++;
      give_verdict();
   end

   initial
   begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      host.leg_read(IDX_ENABLE, rd);
      chk("legacy enable", 16'h0040, 16'(rd));
      host.io_read(PORT_INDEX, rd);
      chk("index readback", 16'h0037, 16'(rd));
      host.io_read(PORT_CTRL, rd);
      chk("direct control", 16'h0000, 16'(rd));
      end_test("reset");

      host.leg_set_limit(24'h00_0002);
      host.leg_write(IDX_ACT, 8'h50);
      host.leg_write(IDX_ENABLE, 8'h40);
      // At most one tick fits in this span, so a limit of two cannot be reached
      repeat (2990) @(negedge clk);
      host.leg_read(IDX_STATUS, rd);
      chk("legacy flag early", 16'h0000, 16'(rd));
      wait_evt(3300);
      chk("legacy irq", 16'h0080, irq);
      chk("legacy nmi", 16'h0000, 16'(nmi));
      host.leg_read(IDX_STATUS, rd);
      chk("legacy flag", 16'h0080, 16'(rd));
      host.leg_write(IDX_STATUS, 8'h40);
      host.leg_read(IDX_STATUS, rd);
      chk("legacy flag serviced", 16'h0000, 16'(rd));
      chk("legacy irq serviced", 16'h0000, irq);
      for (int i = 0; i < 8; i++)
      begin
         if (i < 4)
         begin
            host.leg_write(IDX_ENABLE, 8'h00);
            host.leg_write(IDX_ENABLE, 8'h40);
         end
         else
            host.leg_write(IDX_STATUS, 8'h40);
         repeat (2000) @(negedge clk);
      end
      chk("legacy kept alive", 16'h0000, irq);
      host.leg_write(IDX_ENABLE, 8'h00);
      end_test("legacy");

      host.io_write(PORT_CTRL, 8'h00);
      host.io_write(PORT_LIM_LO, 8'h01);
      host.io_write(PORT_LIM_MID, 8'h00);
      host.io_write(PORT_LIM_HI, 8'h00);
      for (int i = 0; i < 11; i++)
      begin
         host.io_write(PORT_CTRL, 8'h00);
         host.io_write(PORT_STATUS, 8'h80);
         host.io_write(PORT_ACT, {code_tab[i], 4'h0});
         host.io_write(PORT_CTRL, 8'h40);
         wait_evt(3200);
         chk("direct irq", irq_tab[i], irq);
         chk("direct nmi", 16'(code_tab[i] == ACT_NMI), 16'(nmi));
      end
      end_test("direct codes");

      host.io_write(PORT_CTRL, 8'h00);
      host.io_write(PORT_STATUS, 8'h80);
      host.io_write(PORT_ACT, 8'hd0);
      host.io_write(PORT_CTRL, 8'h40);
      wait_evt(3200);
      chk("reset request", 16'h0001, 16'(rst_req));
      chk("irq with reset", 16'h0000, irq);
      @(negedge clk);
      chk("reset request pulse", 16'h0000, 16'(rst_req));
      host.io_read(PORT_STATUS, rd);
      chk("direct flag", 16'h0080, 16'(rd));
      host.io_write(PORT_STATUS, 8'h00);
      host.io_read(PORT_STATUS, rd);
      chk("flag after zero write", 16'h0080, 16'(rd));
      host.io_write(PORT_STATUS, 8'h80);
      host.io_read(PORT_STATUS, rd);
      chk("flag after clear", 16'h0000, 16'(rd));
      end_test("direct reset");

      host.io_write(PORT_CTRL, 8'h00);
      host.io_write(PORT_LIM_LO, 8'h02);
      host.io_write(PORT_ACT, 8'hcf);
      host.io_read(PORT_ACT, rd);
      chk("direct action", 16'h00c0, 16'(rd));
      host.io_write(PORT_CTRL, 8'h40);
      for (int i = 0; i < 4; i++)
      begin
         host.reload(8'(i * 85));
         repeat (2000) @(negedge clk);
      end
      chk("nmi kept off", 16'h0000, 16'(nmi));
      wait_evt(6300);
      chk("direct nmi late", 16'h0001, 16'(nmi));
      host.io_read(PORT_RELOAD, rd);
      chk("reload readback", 16'h0000, 16'(rd));
      end_test("direct reload");
      give_verdict();
   end
endmodule
